// ==== hdl/sgra_params.svh ====
// Constants of the serial rate-adapting port.
`ifndef SGRA_PARAMS_SVH
`define SGRA_PARAMS_SVH
`define SGRA_IDX_BASIC 10'h000
`define SGRA_IDX_SECOND_CFG 10'h014
`define SGRA_IDX_LSCFG 10'h16f
`define SGRA_IDX_DIS 10'h1df
`define SGRA_IDX_STAT 10'h1e0
`define SGRA_BASIC_LOOP 14
`define SGRA_BASIC_ISO 10
`define SGRA_AN_EN_BIT 7
`define SGRA_RA_BIT 7
`define SGRA_DIS_BIT 0
`define SGRA_RST_BASIC 32'h0000_0000
`define SGRA_RST_SECOND_CFG 32'h0000_0080
`define SGRA_RST_LSCFG 32'h0000_0080
`define SGRA_RST_DIS 32'h0000_0000
`define SGRA_REP_100M 7'h0a
`define SGRA_REP_10M 7'h64
`define SGRA_CLK_NS 8
`define SGRA_LINK_TIMER_NS 1600000
`define SGRA_CFG_BASE 16'h0001
`define SGRA_CFG_LINK 15
`define SGRA_CFG_ACK 14
`define SGRA_CFG_SPD_LO 10
`define SGRA_RESP_OKAY 2'b00
`define SGRA_RESP_SLVERR 2'b10
`endif

// ==== hdl/sgra_pkg.sv ====
// Types shared by the serial rate-adapting port.
package sgra_pkg;
    typedef enum logic [1:0] {SGRA_SPD_10, SGRA_SPD_100, SGRA_SPD_1000} sgra_speed_t;
    typedef enum logic [1:0] {AN_OFF, AN_SEND, AN_SETTLE, AN_UP} sgra_an_state_t;
endpackage

// ==== hdl/sgra_rep_cnt.sv ====
// Copy counter that marks the last cycle of a replication group.
`timescale 1ns/1ps
module sgra_rep_cnt #(
    parameter int W = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clr_i,
    input wire logic step_i,
    input wire logic [W-1:0] limit_i,
    output logic [W-1:0] count_o,
    output logic last_o
);
    logic [W-1:0] next_count;

    assign last_o = (count_o == limit_i);

    always_comb begin
        next_count = count_o;
        if (clr_i) begin
            next_count = '0;
        end else if (step_i) begin
            next_count = last_o ? '0 : count_o + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= '0;
        end else begin
            count_o <= next_count;
        end
    end
endmodule

// ==== hdl/sgra_port.sv ====
// Byte-level rate adaption, negotiation and registers of the serial MAC-side port.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "sgra_params.svh"
module sgra_port #(
    parameter int LINK_TIMER_CYC = `SGRA_LINK_TIMER_NS / `SGRA_CLK_NS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic serial_strap_i,
    input wire logic [1:0] media_speed_i,
    input wire logic media_link_i,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_last_i,
    output logic tx_ready_o,
    output logic [7:0] pcs_tx_data_o,
    output logic pcs_tx_en_o,
    output logic pcs_tx_sof_o,
    input wire logic [7:0] pcs_rx_data_i,
    input wire logic pcs_rx_en_i,
    input wire logic pcs_rx_sof_i,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_sof_o,
    output logic [15:0] cfg_tx_word_o,
    output logic cfg_tx_en_o,
    input wire logic [15:0] cfg_rx_word_i,
    input wire logic cfg_rx_valid_i,
    output logic serial_on_o,
    output logic link_up_o
);
    logic strap_done, next_strap_done, serial_strap, next_serial_strap;
    logic [31:0] reg_basic, reg_second_cfg, reg_lscfg, reg_dis;
    logic [31:0] next_basic, next_second_cfg, next_lscfg, next_dis;
    logic aw_full, next_aw_full, w_full, next_w_full;
    logic [9:0] aw_idx, next_aw_idx;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata, rd_word;
    logic rd_hit;
    sgra_pkg::sgra_an_state_t an_state, next_an_state;
    logic [17:0] an_timer, next_an_timer;
    logic [1:0] last_speed, next_last_speed;
    logic last_mlink, next_last_mlink;
    logic an_en, path_on, loop_on, speed_ok, restart;
    logic [6:0] rep_lim;
    logic busy, next_busy, in_frame, next_in_frame, sof, next_sof;
    logic [7:0] cur, next_cur;
    logic tx_take, tx_last_copy;
    logic [6:0] tx_cnt, rx_cnt;
    logic rx_last;
    logic [7:0] rx_src_data;
    logic rx_src_en, rx_src_sof, rx_keep;
    logic [7:0] next_rx_data;
    logic next_rx_valid, next_rx_sof;

    assign an_en = reg_second_cfg[`SGRA_AN_EN_BIT];
    assign loop_on = reg_basic[`SGRA_BASIC_LOOP];
    // Isolate is stored only; the serial pins answer to the strap and the disable register alone.
    assign path_on = serial_strap & ~reg_dis[`SGRA_DIS_BIT];
    // Low-speed transmit stays blocked until rate adapt is cleared, so stale setups fail safe.
    assign speed_ok = !(media_speed_i == 2'(sgra_pkg::SGRA_SPD_10) && reg_lscfg[`SGRA_RA_BIT]);
    assign serial_on_o = path_on;
    assign link_up_o = (an_state == sgra_pkg::AN_UP);

    always_comb begin
        case (media_speed_i)
            2'(sgra_pkg::SGRA_SPD_100): rep_lim = `SGRA_REP_100M - 7'h01;
            2'(sgra_pkg::SGRA_SPD_10): rep_lim = `SGRA_REP_10M - 7'h01;
            default: rep_lim = 7'h00;
        endcase
    end

    // Strap is caught at the first edge after reset release.
    always_comb begin
        next_strap_done = 1'b1;
        next_serial_strap = strap_done ? serial_strap : serial_strap_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strap_done <= 1'b0;
            serial_strap <= 1'b0;
        end else begin
            strap_done <= next_strap_done;
            serial_strap <= next_serial_strap;
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    always_comb begin
        rd_hit = 1'b1;
        case (s_axi_araddr[11:2])
            `SGRA_IDX_BASIC: rd_word = reg_basic;
            `SGRA_IDX_SECOND_CFG: rd_word = reg_second_cfg;
            `SGRA_IDX_LSCFG: rd_word = reg_lscfg;
            `SGRA_IDX_DIS: rd_word = reg_dis;
            `SGRA_IDX_STAT: rd_word = {26'h0, serial_strap, path_on, link_up_o, media_link_i, media_speed_i};
            default: begin
                rd_word = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    always_comb begin
        next_aw_full = aw_full;
        next_aw_idx = aw_idx;
        next_w_full = w_full;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_basic = reg_basic;
        next_second_cfg = reg_second_cfg;
        next_lscfg = reg_lscfg;
        next_dis = reg_dis;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_full = 1'b1;
            next_aw_idx = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_full = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (aw_full && w_full) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = `SGRA_RESP_OKAY;
            case (aw_idx)
                `SGRA_IDX_BASIC: next_basic = merge(reg_basic, w_data, w_strb);
                `SGRA_IDX_SECOND_CFG: next_second_cfg = merge(reg_second_cfg, w_data, w_strb);
                `SGRA_IDX_LSCFG: next_lscfg = merge(reg_lscfg, w_data, w_strb);
                `SGRA_IDX_DIS: next_dis = merge(reg_dis, w_data, w_strb);
                `SGRA_IDX_STAT: next_bresp = `SGRA_RESP_OKAY;
                default: next_bresp = `SGRA_RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata = rd_word;
            next_rresp = rd_hit ? `SGRA_RESP_OKAY : `SGRA_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aw_full <= 1'b0;
            aw_idx <= 10'h000;
            w_full <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SGRA_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `SGRA_RESP_OKAY;
            reg_basic <= `SGRA_RST_BASIC;
            reg_second_cfg <= `SGRA_RST_SECOND_CFG;
            reg_lscfg <= `SGRA_RST_LSCFG;
            reg_dis <= `SGRA_RST_DIS;
        end else begin
            aw_full <= next_aw_full;
            aw_idx <= next_aw_idx;
            w_full <= next_w_full;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
            reg_basic <= next_basic;
            reg_second_cfg <= next_second_cfg;
            reg_lscfg <= next_lscfg;
            reg_dis <= next_dis;
        end
    end

    // A change of media result restarts negotiation so the MAC learns the new speed.
    assign restart = !path_on || !media_link_i || media_speed_i != last_speed || media_link_i != last_mlink;

    always_comb begin
        next_an_state = an_state;
        next_an_timer = an_timer;
        next_last_speed = media_speed_i;
        next_last_mlink = media_link_i;
        case (an_state)
            sgra_pkg::AN_OFF: begin
                next_an_timer = 18'h0;
                if (!restart) begin
                    next_an_state = an_en ? sgra_pkg::AN_SEND : sgra_pkg::AN_UP;
                end
            end
            sgra_pkg::AN_SEND: begin
                if (cfg_rx_valid_i && cfg_rx_word_i[`SGRA_CFG_ACK]) begin
                    next_an_state = sgra_pkg::AN_SETTLE;
                end
            end
            sgra_pkg::AN_SETTLE: begin
                next_an_timer = an_timer + 18'h1;
                if (an_timer == 18'(LINK_TIMER_CYC - 1)) begin
                    next_an_state = sgra_pkg::AN_UP;
                    next_an_timer = 18'h0;
                end
            end
            sgra_pkg::AN_UP: begin
                next_an_timer = 18'h0;
            end
            default: next_an_state = sgra_pkg::AN_OFF;
        endcase
        if (restart) begin
            next_an_state = sgra_pkg::AN_OFF;
        end
        if (an_state != sgra_pkg::AN_OFF && an_state != sgra_pkg::AN_UP && !an_en) begin
            next_an_state = sgra_pkg::AN_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            an_state <= sgra_pkg::AN_OFF;
            an_timer <= 18'h0;
            last_speed <= 2'b00;
            last_mlink <= 1'b0;
            cfg_tx_en_o <= 1'b0;
            cfg_tx_word_o <= 16'h0;
        end else begin
            an_state <= next_an_state;
            an_timer <= next_an_timer;
            last_speed <= next_last_speed;
            last_mlink <= next_last_mlink;
            cfg_tx_en_o <= an_en && (next_an_state == sgra_pkg::AN_SEND || next_an_state == sgra_pkg::AN_SETTLE);
            cfg_tx_word_o <= `SGRA_CFG_BASE | (16'(media_link_i) << `SGRA_CFG_LINK)
                | (16'(next_an_state == sgra_pkg::AN_SETTLE) << `SGRA_CFG_ACK)
                | (16'(media_speed_i) << `SGRA_CFG_SPD_LO);
        end
    end

    // No length counter: frame size is bounded only by the source, so jumbo frames pass.
    assign tx_ready_o = link_up_o & speed_ok & (~busy | tx_last_copy);
    assign tx_take = tx_valid_i & tx_ready_o;

    sgra_rep_cnt #(.W(7)) u_tx_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(tx_take),
        .step_i(busy),
        .limit_i(rep_lim),
        .count_o(tx_cnt),
        .last_o(tx_last_copy)
    );

    always_comb begin
        next_busy = busy;
        next_cur = cur;
        next_in_frame = in_frame;
        next_sof = 1'b0;
        if (tx_take) begin
            next_busy = 1'b1;
            next_cur = tx_data_i;
            next_sof = ~in_frame;
            next_in_frame = ~tx_last_i;
        end else if (busy && tx_last_copy) begin
            next_busy = 1'b0;
        end
        if (!link_up_o) begin
            next_busy = 1'b0;
            next_in_frame = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy <= 1'b0;
            cur <= 8'h00;
            in_frame <= 1'b0;
            sof <= 1'b0;
        end else begin
            busy <= next_busy;
            cur <= next_cur;
            in_frame <= next_in_frame;
            sof <= next_sof;
        end
    end

    // Only data goes to the coder; no transmit clock leaves, the far end recovers timing from the symbols.
    assign pcs_tx_data_o = cur;
    // Enable stays up through every copy, so the coder gets a byte each symbol slot at any speed.
    assign pcs_tx_en_o = busy;
    assign pcs_tx_sof_o = sof;

    // Loopback turns the replicated stream around at the same media-chosen speed.
    assign rx_src_data = loop_on ? cur : pcs_rx_data_i;
    assign rx_src_en = loop_on ? busy : pcs_rx_en_i;
    assign rx_src_sof = loop_on ? sof : pcs_rx_sof_i;

    sgra_rep_cnt #(.W(7)) u_rx_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(rx_src_sof),
        .step_i(rx_src_en),
        .limit_i(rep_lim),
        .count_o(rx_cnt),
        .last_o(rx_last)
    );

    // The start copy clears the counter, so the first copy of each later byte is the wrap cycle.
    assign rx_keep = rx_src_en && (rx_src_sof || rx_last);

    always_comb begin
        next_rx_valid = rx_keep & path_on;
        next_rx_data = rx_keep ? rx_src_data : rx_data_o;
        next_rx_sof = rx_keep & rx_src_sof;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= 8'h00;
            rx_sof_o <= 1'b0;
        end else begin
            rx_valid_o <= next_rx_valid;
            rx_data_o <= next_rx_data;
            rx_sof_o <= next_rx_sof;
        end
    end

    a_an_default_on: assert property (@(posedge clk_i) $fell(rst_i) |-> reg_second_cfg[`SGRA_AN_EN_BIT])
        else $error("negotiation not enabled after reset");
    a_forced_speed_up: assert property (@(posedge clk_i) disable iff (rst_i)
        (!an_en && !restart && an_state == sgra_pkg::AN_OFF) |=> link_up_o)
        else $error("forced mode did not come up");
    a_an_needs_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        (an_en && an_state == sgra_pkg::AN_SEND && !(cfg_rx_valid_i && cfg_rx_word_i[`SGRA_CFG_ACK]) && !restart)
        |=> an_state == sgra_pkg::AN_SEND)
        else $error("negotiation left send without partner ack");
    a_rep_hundred: assert property (@(posedge clk_i) disable iff (rst_i)
        (busy && media_speed_i == 2'(sgra_pkg::SGRA_SPD_100) && tx_cnt != (`SGRA_REP_100M - 7'h01))
        |-> !tx_ready_o)
        else $error("byte not held for ten copies");
    a_sof_single: assert property (@(posedge clk_i) disable iff (rst_i)
        pcs_tx_sof_o |=> !pcs_tx_sof_o)
        else $error("start marker repeated");
    a_rx_one_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        (rx_src_en && !rx_src_sof && !rx_last) |=> !rx_valid_o)
        else $error("replicated byte passed");
    a_iso_no_effect: assert property (@(posedge clk_i) disable iff (rst_i)
        serial_on_o == (serial_strap && !reg_dis[`SGRA_DIS_BIT]))
        else $error("port enable depends on something else");
    a_low_rate_block: assert property (@(posedge clk_i) disable iff (rst_i)
        (media_speed_i == 2'(sgra_pkg::SGRA_SPD_10) && reg_lscfg[`SGRA_RA_BIT]) |-> !tx_ready_o)
        else $error("low speed ran with rate adapt set");
    a_strap_held: assert property (@(posedge clk_i) disable iff (rst_i)
        strap_done |=> $stable(serial_strap))
        else $error("strap changed after capture");
endmodule

// ==== test/sgra_mac_model.sv ====
// Behavioural MAC partner that answers negotiation and can echo the byte stream.
`timescale 1ns/1ps
module sgra_mac_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic echo_i,
    input wire logic [15:0] word_i,
    input wire logic word_en_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_en_i,
    input wire logic byte_sof_i,
    output logic [15:0] word_o,
    output logic word_valid_o,
    output logic [7:0] byte_o,
    output logic byte_en_o,
    output logic byte_sof_o
);
    logic [5:0] wait_q;
    logic [15:0] last_q;
    // Between answers the reply word changes every cycle, so a stale word is never taken for a fresh one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_q <= 6'h00;
            last_q <= 16'h0000;
            word_o <= 16'hffff;
            word_valid_o <= 1'b0;
            byte_o <= 8'h00;
            byte_en_o <= 1'b0;
            byte_sof_o <= 1'b0;
        end else begin
            word_valid_o <= 1'b0;
            word_o <= ~last_q;
            last_q <= ~last_q;
            wait_q <= word_en_i ? wait_q + 6'h01 : 6'h00;
            if (word_en_i && wait_q == (slow_i ? 6'h1e : 6'h02)) begin
                word_o <= word_i | 16'h4001;
                last_q <= word_i | 16'h4001;
                word_valid_o <= 1'b1;
                wait_q <= 6'h00;
            end
            // Data returns on its own pair with no separate clock.
            byte_en_o <= echo_i & byte_en_i;
            byte_sof_o <= echo_i & byte_sof_i;
            byte_o <= (echo_i & byte_en_i) ? byte_i : ~byte_o;
        end
    end
endmodule

// ==== test/tb_serial_gmii_rate_adapt_port.sv ====
// Self-checking testbench of the serial rate-adapting port.
`timescale 1ns/1ps
module tb_serial_gmii_rate_adapt_port;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic serial_strap_i = 1'b1;
    logic [1:0] media_speed_i = 2'h2;
    logic media_link_i = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b1;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic tx_valid_i = 1'b0;
    logic tx_last_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic slow = 1'b0;
    logic echo = 1'b0;
    logic tx_ready_o, pcs_tx_en_o, pcs_tx_sof_o, pcs_rx_en_i, pcs_rx_sof_i, rx_valid_o, rx_sof_o;
    logic cfg_tx_en_o, cfg_rx_valid_i, serial_on_o, link_up_o;
    logic [7:0] pcs_tx_data_o, pcs_rx_data_i, rx_data_o;
    logic [15:0] cfg_tx_word_o, cfg_rx_word_i;
    int mismatches = 0;
    int checks = 0;
    int sofs = 0;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];

    sgra_port #(.LINK_TIMER_CYC(20)) u_sgra_port (.clk_i, .rst_i, .serial_strap_i, .media_speed_i, .media_link_i,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_valid_i, .tx_data_i, .tx_last_i, .tx_ready_o,
        .pcs_tx_data_o, .pcs_tx_en_o, .pcs_tx_sof_o, .pcs_rx_data_i, .pcs_rx_en_i, .pcs_rx_sof_i, .rx_data_o,
        .rx_valid_o, .rx_sof_o, .cfg_tx_word_o, .cfg_tx_en_o, .cfg_rx_word_i, .cfg_rx_valid_i, .serial_on_o,
        .link_up_o);

    sgra_mac_model u_sgra_mac_model (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .echo_i(echo),
        .word_i(cfg_tx_word_o), .word_en_i(cfg_tx_en_o), .byte_i(pcs_tx_data_o), .byte_en_i(pcs_tx_en_o),
        .byte_sof_i(pcs_tx_sof_o), .word_o(cfg_rx_word_i), .word_valid_o(cfg_rx_valid_i),
        .byte_o(pcs_rx_data_i), .byte_en_o(pcs_rx_en_i), .byte_sof_o(pcs_rx_sof_i));

    always #4 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (pcs_tx_en_o === 1'b1) txq.push_back(pcs_tx_data_o);
        if (pcs_tx_sof_o === 1'b1) sofs++;
        if (rx_valid_o === 1'b1) rxq.push_back(rx_data_o);
    end

    task automatic conclude();
        if (mismatches == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic stuck(input string nm);
        mismatches++;
        $display("mismatch %s expected answer seen timeout", nm);
        conclude();
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        logic ta, tw, tb;
        logic [1:0] r;
        n = 0;
        tb = 1'b0;
        r = 2'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!tb && n < 64) begin
            @(negedge clk_i);
            ta = s_axi_awvalid && s_axi_awready === 1'b1;
            tw = s_axi_wvalid && s_axi_wready === 1'b1;
            tb = s_axi_bvalid === 1'b1;
            r = s_axi_bresp;
            @(posedge clk_i);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n++;
        end
        if (!tb) stuck("bvalid");
        chk("bresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        logic ta, tb;
        logic [1:0] r;
        logic [31:0] d;
        n = 0;
        tb = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!tb && n < 64) begin
            @(negedge clk_i);
            ta = s_axi_arvalid && s_axi_arready === 1'b1;
            tb = s_axi_rvalid === 1'b1;
            r = s_axi_rresp;
            d = s_axi_rdata;
            @(posedge clk_i);
            if (ta) s_axi_arvalid <= 1'b0;
            n++;
        end
        if (!tb) stuck("rvalid");
        chk("rdata", e, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic speed(input logic [1:0] s, input logic an);
        int n;
        logic seen, up;
        n = 0;
        seen = 1'b0;
        up = 1'b0;
        media_speed_i <= s;
        repeat (2) @(posedge clk_i);
        while (!up && n < 400) begin
            @(negedge clk_i);
            if (cfg_tx_en_o === 1'b1 && !seen)
                chk("cfg word", {28'h0, 1'b1, s, 1'b1},
                    {28'h0, cfg_tx_word_o[15], cfg_tx_word_o[11:10], cfg_tx_word_o[0]});
            seen = seen | (cfg_tx_en_o === 1'b1);
            up = link_up_o === 1'b1;
            @(posedge clk_i);
            n++;
        end
        if (!up) stuck("link");
        chk("negotiating", {31'h0, an}, {31'h0, seen});
    endtask

    task automatic frame(input int nb, input int rep);
        int n, bad;
        logic t;
        txq.delete();
        rxq.delete();
        sofs = 0;
        bad = 0;
        for (int i = 0; i < nb; i++) begin
            tx_valid_i <= 1'b1;
            tx_data_i <= 8'(i * 5 + 1);
            tx_last_i <= (i == nb - 1);
            n = 0;
            do begin
                @(negedge clk_i);
                t = tx_ready_o === 1'b1;
                @(posedge clk_i);
                n++;
            end while (!t && n < 300);
            if (!t) stuck("tx ready");
        end
        tx_valid_i <= 1'b0;
        tx_last_i <= 1'b0;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (pcs_tx_en_o === 1'b1 && n < 300);
        repeat (4) @(posedge clk_i);
        foreach (txq[k]) if (txq[k] !== 8'(k / rep * 5 + 1)) bad++;
        foreach (rxq[k]) if (rxq[k] !== 8'(k * 5 + 1)) bad++;
        chk("copies", nb * rep, txq.size());
        chk("bytes", 0, bad);
        chk("sof", 1, sofs);
        chk("kept", nb, rxq.size());
    endtask

    initial begin
        repeat (100000) @(posedge clk_i);
        stuck("run");
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(12'h050, 32'h80, 2'h0);
        rd(12'h5bc, 32'h80, 2'h0);
        rd(12'h000, 32'h0, 2'h0);
        rd(12'h77c, 32'h0, 2'h0);
        rd(12'h004, 32'h0, 2'h2);
        wr(12'h004, 32'h1, 2'h2);
        speed(2'h2, 1'b1);
        rd(12'h780, 32'h3e, 2'h0);
        wr(12'h780, 32'h0, 2'h0);
        rd(12'h780, 32'h3e, 2'h0);
        wr(12'h000, 32'h4000, 2'h0);
        frame(1600, 1);
        slow <= 1'b1;
        speed(2'h1, 1'b1);
        frame(1600, 10);
        wr(12'h050, 32'h0, 2'h0);
        speed(2'h0, 1'b0);
        chk("10M held", 32'h0, {31'h0, tx_ready_o});
        wr(12'h5bc, 32'h0, 2'h0);
        frame(3, 100);
        wr(12'h000, 32'h400, 2'h0);
        echo <= 1'b1;
        speed(2'h1, 1'b0);
        frame(5, 10);
        chk("isolated", 32'h1, {31'h0, serial_on_o});
        wr(12'h77c, 32'h1, 2'h0);
        repeat (2) @(posedge clk_i);
        chk("port off", 32'h0, {31'h0, serial_on_o});
        rd(12'h780, 32'h25, 2'h0);
        wr(12'h77c, 32'h0, 2'h0);
        serial_strap_i <= 1'b0;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        chk("strap off", 32'h0, {31'h0, serial_on_o});
        chk("no link", 32'h0, {31'h0, link_up_o});
        rd(12'h050, 32'h80, 2'h0);
        conclude();
    end
endmodule
